// ### rtl/sdram_info_and_burst_order.sv
// Purpose: Device information and feature registers with burst column sequencing
// Assumes: Commands already decoded from the command/address bus, one per clock
// Notes:   One beat column is produced per clock while a burst runs
//
// How it works
// - Bit 0 reports auto-initialization still running.
// - Bit 1 device kind, bit 2 no data-invalid.
// - Bits 4:3 hold the self-test result code.
// - Init calibration write updates self-test field.
// - Pin tied to supply forces result 01.
// - Faulty result: factory trim, calibration commands ignored.
// - Bit 4 no-wrap, legal only with 4 beats.
// - Precharge starts write recovery code plus 2 cycles after the last write beat.
// - Lowest start column bit forced to zero.
// - Wrapped ordering touches only low column bits.
// - No-wrap delivers y to y+3 linearly.
// - Reserved bits read back as zero.
// - Writes to read-only register change nothing.
// - Other reads give zero data, strobe toggles.

`timescale 1ns/1ps
`default_nettype none

module sdram_info_and_burst_order (
   // Clock and reset
   input  wire  logic                          sys_clk,
   input  wire  logic                          resetn,
   // Mode register command port
   input  wire  sdram_info_pkg::mr_cmd_t       mr_cmd,
   // Device status inputs
   input  wire  logic                          auto_init_busy,
   input  wire  logic                          device_is_nvm,
   input  wire  logic                          calibration_pin_tied_supply,
   input  wire  logic [1:0]                    calibration_pin_test,
   // Burst request
   input  wire  logic                          burst_start,
   input  wire  logic                          burst_is_write,
   input  wire  logic                          auto_precharge,
   input  wire  logic [9:0]                    burst_start_col,
   // Mode register read answer
   output var   logic                          mr_read_valid_ff,
   output var   logic [7:0]                    mr_read_data_ff,
   output var   logic                          mr_read_strobe_ff,
   // Calibration control
   output var   logic                          calib_run_ff,
   output var   logic                          use_factory_trim_ff,
   // Burst outputs
   output var   logic                          beat_valid_ff,
   output var   logic [9:0]                    beat_col_ff,
   output var   logic                          beat_last_ff,
   output var   logic                          burst_busy_ff,
   output var   logic                          precharge_start_ff,
   output var   logic                          config_illegal_ff
);

   // --------------------------------------------------------------------------
   // Helper functions
   // --------------------------------------------------------------------------

   // Column mask of the bits that the ordering acts on
   function automatic logic [9:0] bl_mask(input logic [2:0] bl);
      begin
         unique case (bl)
            sdram_info_pkg::BL_CODE_8:  bl_mask = sdram_info_pkg::MASK_8;
            sdram_info_pkg::BL_CODE_16: bl_mask = sdram_info_pkg::MASK_16;
            default:                    bl_mask = sdram_info_pkg::MASK_4;
         endcase
      end
   endfunction

   // Index of the final beat for a length code
   function automatic logic [3:0] last_index(input logic [2:0] bl);
      begin
         last_index = 4'(bl_mask(bl));
      end
   endfunction

   // Column of one beat from start column and beat index
   function automatic logic [9:0] beat_column(input logic [9:0] start,
                                              input logic [3:0] idx,
                                              input sdram_info_pkg::feature_t f);
      logic [9:0] mask;
      logic [9:0] step;
      logic [9:0] low;
      begin
         mask = bl_mask(f.burst_length);
         step = {6'h00, idx};
         if (f.burst_type) begin
            low = (start ^ step) & mask;
         end else begin
            low = (start + step) & mask;
         end
         if (f.wrap_control) begin
            beat_column = start + step;
         end else begin
            beat_column = (start & ~mask) | low;
         end
      end
   endfunction

   // Self-test fault: assembly error possible
   function automatic logic selftest_fault(input logic [1:0] st);
      begin
         selftest_fault = (st == sdram_info_pkg::ST_SUPPLY) ||
                          (st == sdram_info_pkg::ST_GROUND);
      end
   endfunction

   // --------------------------------------------------------------------------
   // Register state
   // --------------------------------------------------------------------------
   sdram_info_pkg::feature_t     feature_ff;     // Feature register
   logic [1:0]                   selftest_ff;    // Self-test result
   sdram_info_pkg::burst_state_t state_ff;       // Burst state
   logic [9:0]                   start_col_ff;   // Latched even start column
   sdram_info_pkg::feature_t     burst_cfg_ff;   // Configuration of running burst
   logic [3:0]                   beat_idx_ff;    // Current beat index
   logic                         recover_ff;     // Write burst needs auto-precharge
   logic [3:0]                   wr_cnt_ff;      // Recovery countdown
   sdram_info_pkg::info_t        info;           // Assembled information byte
   logic                         wr_feat;        // Write to feature register
   logic                         wr_cal;         // Write to calibration register
   logic                         cal_valid;      // Known calibration code

   assign wr_feat   = mr_cmd.wr && (mr_cmd.addr == sdram_info_pkg::MR_FEAT_ADDR);
   assign wr_cal    = mr_cmd.wr && (mr_cmd.addr == sdram_info_pkg::MR_CAL_ADDR);
   assign cal_valid = (mr_cmd.data == sdram_info_pkg::CAL_INIT_CODE)  ||
                      (mr_cmd.data == sdram_info_pkg::CAL_LONG_CODE)  ||
                      (mr_cmd.data == sdram_info_pkg::CAL_SHORT_CODE) ||
                      (mr_cmd.data == sdram_info_pkg::CAL_RESET_CODE);

   // Information byte from live status and stored result
   always_comb begin
      info.reserved_field          = '0;
      info.calib_resistor_selftest = selftest_ff;
      info.invalid_data_support    = 1'b1;
      info.device_kind_flag        = device_is_nvm;
      info.auto_init_status        = auto_init_busy;
   end

   // --------------------------------------------------------------------------
   // Mode register writes
   // --------------------------------------------------------------------------

   // Feature register; writes elsewhere, including the info address, are dropped
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         feature_ff <= sdram_info_pkg::FEAT_RESET;
      end else if (wr_feat) begin
         feature_ff <= mr_cmd.data;
      end
   end

   // Self-test result captured when the init calibration command is written
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         selftest_ff <= sdram_info_pkg::ST_NOT_RUN;
      end else if (wr_cal && (mr_cmd.data == sdram_info_pkg::CAL_INIT_CODE)) begin
         if (calibration_pin_tied_supply) begin
            selftest_ff <= sdram_info_pkg::ST_SUPPLY;
         end else begin
            selftest_ff <= calibration_pin_test;
         end
      end
   end

   // Calibration commands run only while no fault is recorded
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         calib_run_ff        <= 1'b0;
         use_factory_trim_ff <= 1'b0;
      end else begin
         calib_run_ff        <= wr_cal && cal_valid && !selftest_fault(selftest_ff);
         use_factory_trim_ff <= selftest_fault(selftest_ff);
      end
   end

   // --------------------------------------------------------------------------
   // Mode register reads
   // --------------------------------------------------------------------------

   // One-cycle answer; non-readable addresses return zero but still strobe
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mr_read_valid_ff  <= 1'b0;
         mr_read_data_ff   <= 8'h00;
         mr_read_strobe_ff <= 1'b0;
      end else begin
         mr_read_valid_ff  <= mr_cmd.rd;
         mr_read_strobe_ff <= mr_cmd.rd;
         if (mr_cmd.rd && (mr_cmd.addr == sdram_info_pkg::MR_INFO_ADDR)) begin
            mr_read_data_ff <= info;
         end else begin
            mr_read_data_ff <= 8'h00;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Configuration check
   // --------------------------------------------------------------------------

   // Flags reserved codes and forbidden combinations in the feature register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         config_illegal_ff <= 1'b0;
      end else begin
         config_illegal_ff <=
            ((feature_ff.burst_length != sdram_info_pkg::BL_CODE_4) &&
             (feature_ff.burst_length != sdram_info_pkg::BL_CODE_8) &&
             (feature_ff.burst_length != sdram_info_pkg::BL_CODE_16)) ||
            (feature_ff.wrap_control &&
             (feature_ff.burst_length != sdram_info_pkg::BL_CODE_4)) ||
            (feature_ff.burst_type &&
             (feature_ff.burst_length == sdram_info_pkg::BL_CODE_16)) ||
            (feature_ff.write_recovery_cycles < sdram_info_pkg::WR_CODE_MIN) ||
            (feature_ff.write_recovery_cycles > sdram_info_pkg::WR_CODE_MAX);
      end
   end

   // --------------------------------------------------------------------------
   // Burst sequencer
   // --------------------------------------------------------------------------

   // State, beat index and recovery countdown
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff     <= sdram_info_pkg::ST_IDLE;
         start_col_ff <= 10'h000;
         burst_cfg_ff <= sdram_info_pkg::FEAT_RESET;
         beat_idx_ff  <= 4'h0;
         recover_ff   <= 1'b0;
         wr_cnt_ff    <= 4'h0;
      end else begin
         unique case (state_ff)
            sdram_info_pkg::ST_IDLE: begin
               if (burst_start) begin
                  state_ff     <= sdram_info_pkg::ST_BURST;
                  start_col_ff <= burst_start_col & sdram_info_pkg::COL_EVEN_MASK;
                  burst_cfg_ff <= feature_ff;
                  beat_idx_ff  <= 4'h0;
                  recover_ff   <= burst_is_write && auto_precharge;
               end
            end
            sdram_info_pkg::ST_BURST: begin
               if (beat_idx_ff == last_index(burst_cfg_ff.burst_length)) begin
                  if (recover_ff) begin
                     state_ff  <= sdram_info_pkg::ST_RECOVER;
                     wr_cnt_ff <= {1'b0, burst_cfg_ff.write_recovery_cycles} +
                                  sdram_info_pkg::WR_CODE_OFFSET - 4'h1;
                  end else begin
                     state_ff  <= sdram_info_pkg::ST_IDLE;
                  end
               end else begin
                  beat_idx_ff <= beat_idx_ff + 4'h1;
               end
            end
            sdram_info_pkg::ST_RECOVER: begin
               if (wr_cnt_ff == 4'h0) begin
                  state_ff <= sdram_info_pkg::ST_IDLE;
               end else begin
                  wr_cnt_ff <= wr_cnt_ff - 4'h1;
               end
            end
            default: begin
               state_ff <= sdram_info_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Beat outputs registered from the running burst
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         beat_valid_ff      <= 1'b0;
         beat_col_ff        <= 10'h000;
         beat_last_ff       <= 1'b0;
         burst_busy_ff      <= 1'b0;
         precharge_start_ff <= 1'b0;
      end else begin
         beat_valid_ff      <= (state_ff == sdram_info_pkg::ST_BURST);
         beat_col_ff        <= beat_column(start_col_ff, beat_idx_ff, burst_cfg_ff);
         beat_last_ff       <= (state_ff == sdram_info_pkg::ST_BURST) &&
                               (beat_idx_ff == last_index(burst_cfg_ff.burst_length));
         burst_busy_ff      <= (state_ff != sdram_info_pkg::ST_IDLE) || burst_start;
         precharge_start_ff <= (state_ff == sdram_info_pkg::ST_RECOVER) &&
                               (wr_cnt_ff == 4'h0);
      end
   end

endmodule // sdram_info_and_burst_order

`default_nettype wire

// ### rtl/sdram_info_pkg.sv
// Purpose: Shared constants and carriers for the mode register and burst order block
// Assumes: One mode register command per clock, eight-bit address and data
// Notes:   Field positions, codes and reset values live here only

package sdram_info_pkg;

   // -------------------------------------------------------------------------
   // Mode register addresses and codes
   // -------------------------------------------------------------------------
   localparam logic [7:0] MR_INFO_ADDR   = 8'h00;  // Device information, read-only
   localparam logic [7:0] MR_FEAT_ADDR   = 8'h01;  // Device feature one, write-only
   localparam logic [7:0] MR_CAL_ADDR    = 8'h0A;  // Calibration command register
   localparam logic [7:0] CAL_INIT_CODE  = 8'hFF;  // Calibration after initialization
   localparam logic [7:0] CAL_LONG_CODE  = 8'hAB;  // Long calibration
   localparam logic [7:0] CAL_SHORT_CODE = 8'h56;  // Short calibration
   localparam logic [7:0] CAL_RESET_CODE = 8'hC3;  // Calibration reset

   // -------------------------------------------------------------------------
   // Feature register layout and reset value
   // -------------------------------------------------------------------------
   localparam logic [7:0] FEAT_RESET     = 8'h22;  // Length 4, sequential, wrap, 3 cycles
   localparam logic [2:0] BL_CODE_4      = 3'h2;   // 4 beats
   localparam logic [2:0] BL_CODE_8      = 3'h3;   // 8 beats
   localparam logic [2:0] BL_CODE_16     = 3'h4;   // 16 beats
   localparam logic [2:0] WR_CODE_MIN    = 3'h1;   // Recovery code for 3 cycles
   localparam logic [2:0] WR_CODE_MAX    = 3'h6;   // Recovery code for 8 cycles
   localparam logic [3:0] WR_CODE_OFFSET = 4'h2;   // Cycles equal code plus this

   // -------------------------------------------------------------------------
   // Self-test result codes
   // -------------------------------------------------------------------------
   localparam logic [1:0] ST_NOT_RUN     = 2'h0;   // Test not executed
   localparam logic [1:0] ST_SUPPLY      = 2'h1;   // Pin tied to supply or floating
   localparam logic [1:0] ST_GROUND      = 2'h2;   // Pin shorted to ground
   localparam logic [1:0] ST_GOOD        = 2'h3;   // Completed without error

   // -------------------------------------------------------------------------
   // Burst geometry
   // -------------------------------------------------------------------------
   localparam int         COL_W          = 10;     // Column address width
   localparam logic [9:0] MASK_4         = 10'h003; // Ordered bits for 4 beats
   localparam logic [9:0] MASK_8         = 10'h007; // Ordered bits for 8 beats
   localparam logic [9:0] MASK_16        = 10'h00F; // Ordered bits for 16 beats
   localparam logic [9:0] COL_EVEN_MASK  = 10'h3FE; // Clears the lowest column bit

   // Feature register fields
   typedef struct packed {
      logic [2:0] write_recovery_cycles;  // Bits 7:5
      logic       wrap_control;           // Bit 4, 1 = no wrap
      logic       burst_type;             // Bit 3, 1 = interleaved
      logic [2:0] burst_length;           // Bits 2:0
   } feature_t;

   // Information register fields
   typedef struct packed {
      logic [2:0] reserved_field;           // Bits 7:5, read as zero
      logic [1:0] calib_resistor_selftest;  // Bits 4:3
      logic       invalid_data_support;     // Bit 2
      logic       device_kind_flag;         // Bit 1
      logic       auto_init_status;         // Bit 0
   } info_t;

   // One mode register command from the controller
   typedef struct packed {
      logic       wr;    // Mode register write strobe
      logic       rd;    // Mode register read strobe
      logic [7:0] addr;  // Register address
      logic [7:0] data;  // Write data
   } mr_cmd_t;

   // Burst state, Gray coded along idle, burst, recover
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_BURST   = 2'b01,
      ST_RECOVER = 2'b11
   } burst_state_t;

endpackage

// ### tb/sdram_host_model.sv
// Purpose: Memory controller model issuing mode register commands and bursts
// Assumes: Requests change at the falling edge and stand for one cycle
// Notes:   Released strobes go low, other released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module sdram_host_model (
   // Clock
   input  wire logic                    sys_clk,
   // Requests towards the device
   output var sdram_info_pkg::mr_cmd_t  mr_cmd,
   output var logic                     burst_start,
   output var logic                     burst_is_write,
   output var logic                     auto_precharge,
   output var logic [9:0]               burst_start_col
);
   // Idle request lines at time zero
   initial begin
      mr_cmd = '0;
      burst_start = 1'h0;
      burst_is_write = 1'h0;
      auto_precharge = 1'h0;
      burst_start_col = 10'h000;
   end
   // One read or write, reserved bits and codes left as the caller keeps them zero
   task automatic mr_issue(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(negedge sys_clk);
      mr_cmd <= {wr, !wr, addr, data};
      @(negedge sys_clk);
      mr_cmd <= {1'h0, 1'h0, ~addr, ~data};
   endtask
   // One burst start from a column clear of the no-wrap boundaries
   task automatic burst_issue(input logic [9:0] col, input logic ap);
      @(negedge sys_clk);
      burst_start <= 1'h1;
      burst_is_write <= ap;
      auto_precharge <= ap;
      burst_start_col <= col;
      @(negedge sys_clk);
      burst_start <= 1'h0;
      burst_is_write <= ~ap;
      auto_precharge <= ~ap;
      burst_start_col <= ~col;
   endtask
endmodule // sdram_host_model
`default_nettype wire

// ### tb/sdram_order_monitor.sv
// Purpose: Port assertions for the mode register and burst order block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached to every instance of the block by the bind below
`timescale 1ns/1ps
`default_nettype none
module sdram_order_monitor (
   // Clock and reset
   input wire logic                    sys_clk,
   input wire logic                    resetn,
   // Watched inputs
   input wire sdram_info_pkg::mr_cmd_t mr_cmd,
   input wire logic                    auto_init_busy,
   input wire logic                    device_is_nvm,
   input wire logic                    calibration_pin_tied_supply,
   input wire logic [9:0]              burst_start_col,
   // Watched outputs
   input wire logic                    mr_read_valid_ff,
   input wire logic [7:0]              mr_read_data_ff,
   input wire logic                    mr_read_strobe_ff,
   input wire logic                    calib_run_ff,
   input wire logic                    use_factory_trim_ff,
   input wire logic                    beat_valid_ff,
   input wire logic [9:0]              beat_col_ff,
   input wire logic                    beat_last_ff,
   input wire logic                    precharge_start_ff,
   input wire logic                    config_illegal_ff
);
   // ----------------------------------------------------------------------
   // Helper logic and sequences
   // ----------------------------------------------------------------------
   logic [3:0] gap_ff;  // Cycles since the last beat, saturating
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Restart the count at each last beat
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) gap_ff <= 4'hF;
      else if (beat_last_ff) gap_ff <= 4'h1;
      else if (gap_ff != 4'hF) gap_ff <= gap_ff + 4'h1;
   end
   sequence s_answer; mr_read_valid_ff && mr_read_strobe_ff; endsequence
   sequence s_run; beat_valid_ff [*4]; endsequence
   sequence s_tail; beat_valid_ff ##1 !beat_valid_ff; endsequence
   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   read_answer_a: assert property (mr_cmd.rd |=> s_answer)
      else $error("read answer missing");
   info_live_a: assert property (mr_cmd.rd && mr_cmd.addr == sdram_info_pkg::MR_INFO_ADDR
      |=> mr_read_data_ff[2:0] == {1'h1, $past(device_is_nvm), $past(auto_init_busy)})
      else $error("information bits wrong");
   reserved_zero_a: assert property (mr_cmd.rd |=> mr_read_data_ff[7:5] == 3'h0)
      else $error("reserved bits not zero");
   other_read_a: assert property (mr_cmd.rd && mr_cmd.addr != 8'h00
      |=> mr_read_data_ff == 8'h00) else $error("unreadable register not zero");
   trim_gate_a: assert property (calib_run_ff |-> !use_factory_trim_ff)
      else $error("calibration ran on factory trim");
   supply_tie_a: assert property (mr_cmd.wr && mr_cmd.addr == 8'h0A && mr_cmd.data == 8'hFF
      && calibration_pin_tied_supply |=> ##1 use_factory_trim_ff) else $error("trim not used");
   beat_run_a: assert property ($rose(beat_valid_ff) |-> s_run)
      else $error("burst shorter than four beats");
   last_tail_a: assert property (beat_last_ff |-> s_tail)
      else $error("last beat misplaced");
   even_start_a: assert property ($rose(beat_valid_ff)
      |-> beat_col_ff == ($past(burst_start_col, 2) & 10'h3FE)) else $error("first column wrong");
   recovery_span_a: assert property (precharge_start_ff |-> gap_ff >= 4'h3 && gap_ff <= 4'h8)
      else $error("precharge outside recovery range");
   illegal_flag_a: assert property (mr_cmd.wr && mr_cmd.addr == 8'h01 && mr_cmd.data == 8'h33
      |=> ##1 config_illegal_ff) else $error("no-wrap with eight beats not flagged");
endmodule // sdram_order_monitor
bind sdram_info_and_burst_order sdram_order_monitor sdram_order_monitor_inst (.sys_clk, .resetn,
   .mr_cmd, .auto_init_busy, .device_is_nvm, .calibration_pin_tied_supply, .burst_start_col,
   .mr_read_valid_ff, .mr_read_data_ff, .mr_read_strobe_ff, .calib_run_ff, .use_factory_trim_ff,
   .beat_valid_ff, .beat_col_ff, .beat_last_ff, .precharge_start_ff, .config_illegal_ff);
`default_nettype wire

// ### tb/test_sdram_info_and_burst_order.sv
// Purpose: Register and burst order tests through mode register commands
// Assumes: Host model drives requests, bench drives status pins at the falling edge
// Notes:   Expected columns are built from the burst length, type and wrap fields
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_sdram_info_and_burst_order;
   logic sys_clk = 1'h0, resetn = 1'h0, auto_init_busy = 1'h1, device_is_nvm = 1'h0;
   logic tied = 1'h0, burst_start, burst_is_write, auto_precharge;
   logic [1:0] self_test = 2'h2;
   logic [9:0] burst_start_col, beat_col_ff;
   logic mr_read_valid_ff, mr_read_strobe_ff, calib_run_ff, use_factory_trim_ff;
   logic beat_valid_ff, beat_last_ff, burst_busy_ff, precharge_start_ff, config_illegal_ff;
   logic [7:0] mr_read_data_ff, codes [5] = '{8'hFF, 8'hAB, 8'h56, 8'hC3, 8'h12};
   logic [7:0] feats [8] = '{8'h22, 8'h23, 8'h2B, 8'h24, 8'h32, 8'h2A, 8'hC3, 8'h22};
   logic [9:0] cols [8] = '{10'h007, 10'h00A, 10'h00A, 10'h3F6, 10'h106, 10'h002, 10'h00C, 10'h000};
   sdram_info_pkg::mr_cmd_t mr_cmd;
   int n_fail = 0, n_compared = 0, cycles = 0;
   always #4 sys_clk = ~sys_clk;
   sdram_host_model sdram_host_model_inst (.sys_clk(sys_clk), .mr_cmd(mr_cmd),
      .burst_start(burst_start), .burst_is_write(burst_is_write),
      .auto_precharge(auto_precharge), .burst_start_col(burst_start_col));
   sdram_info_and_burst_order sdram_info_and_burst_order_inst (.sys_clk(sys_clk),
      .resetn(resetn), .mr_cmd(mr_cmd), .auto_init_busy(auto_init_busy),
      .device_is_nvm(device_is_nvm), .calibration_pin_tied_supply(tied),
      .calibration_pin_test(self_test), .burst_start(burst_start), .burst_is_write(burst_is_write),
      .auto_precharge(auto_precharge), .burst_start_col(burst_start_col),
      .mr_read_valid_ff(mr_read_valid_ff), .mr_read_data_ff(mr_read_data_ff),
      .mr_read_strobe_ff(mr_read_strobe_ff), .calib_run_ff(calib_run_ff),
      .use_factory_trim_ff(use_factory_trim_ff), .beat_valid_ff(beat_valid_ff),
      .beat_col_ff(beat_col_ff), .beat_last_ff(beat_last_ff), .burst_busy_ff(burst_busy_ff),
      .precharge_start_ff(precharge_start_ff), .config_illegal_ff(config_illegal_ff));
   // Prints the verdict and stops
   task automatic finish_test();
      $display("Compared %0d, mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Cuts a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         finish_test();
      end
   end
   // Reads a register and compares the answer byte
   task automatic read_check(input string nm, input logic [7:0] addr, input logic [7:0] ex);
      sdram_host_model_inst.mr_issue(1'h0, addr, 8'h00);
      `CHECK(nm, 1'h1, mr_read_strobe_ff)
      `CHECK(nm, ex, mr_read_data_ff)
   endtask
   // Column of beat i from the feature byte and start column
   function automatic logic [9:0] exp_col(logic [7:0] f, logic [9:0] s, int i);
      logic [9:0] b, m;
      b = s & 10'h3FE;
      m = (f[2:0] == 3'h3) ? 10'h007 : (f[2:0] == 3'h4) ? 10'h00F : 10'h003;
      if (f[4]) return b + 10'(i);
      if (f[3]) return (b & ~m) | ((b ^ 10'(i)) & m);
      return (b & ~m) | ((b + 10'(i)) & m);
   endfunction
   // Runs one burst and checks columns, length and recovery
   task automatic burst_check(input logic [7:0] f, input logic [9:0] s, input logic ap);
      int n = 0, gap = -1, pc = 0;
      sdram_host_model_inst.burst_issue(s, ap);
      repeat (34) begin
         @(negedge sys_clk);
         if (beat_valid_ff === 1'h1) begin
            `CHECK("beat column", exp_col(f, s, n), beat_col_ff)
            `CHECK("busy", 1'h1, burst_busy_ff)
            n++;
            if (beat_last_ff === 1'h1) gap = 0;
         end
         else if (gap >= 0) gap++;
         if (precharge_start_ff === 1'h1) begin
            pc++;
            `CHECK("recovery", int'(f[7:5]) + 2, gap)
         end
      end
      `CHECK("beat count", (f[2:0] == 3'h3) ? 8 : (f[2:0] == 3'h4) ? 16 : 4, n)
      `CHECK("precharge count", int'(ap), pc)
      $display("Test done: burst %0h from %0h", f, s);
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk) resetn = 1'h1;
      read_check("info busy", 8'h00, 8'h05);
      auto_init_busy = 1'h0;
      device_is_nvm = 1'h1;
      read_check("info ready", 8'h00, 8'h06);
      sdram_host_model_inst.mr_issue(1'h1, 8'h00, 8'h1F);
      read_check("info after write", 8'h00, 8'h06);
      read_check("feature read", 8'h01, 8'h00);
      $display("Test done: information register");
      tied = 1'h1;
      sdram_host_model_inst.mr_issue(1'h1, 8'h0A, 8'hFF);
      `CHECK("first calibration", 1'h1, calib_run_ff)
      @(negedge sys_clk);
      `CHECK("factory trim", 1'h1, use_factory_trim_ff)
      read_check("info supply tie", 8'h00, 8'h0E);
      sdram_host_model_inst.mr_issue(1'h1, 8'h0A, 8'hAB);
      `CHECK("ignored calibration", 1'h0, calib_run_ff)
      tied = 1'h0;
      sdram_host_model_inst.mr_issue(1'h1, 8'h0A, 8'hFF);
      read_check("info ground", 8'h00, 8'h16);
      self_test = 2'h3;
      sdram_host_model_inst.mr_issue(1'h1, 8'h0A, 8'hFF);
      read_check("info self test good", 8'h00, 8'h1E);
      for (int i = 0; i < 5; i++) begin
         sdram_host_model_inst.mr_issue(1'h1, 8'h0A, codes[i]);
         `CHECK("calibration code", (i < 4) ? 1'h1 : 1'h0, calib_run_ff)
      end
      $display("Test done: calibration");
      for (int i = 0; i < 8; i++) begin
         sdram_host_model_inst.mr_issue(1'h1, 8'h01, feats[i]);
         burst_check(feats[i], cols[i], (i >= 6) ? 1'h1 : 1'h0);
      end
      sdram_host_model_inst.mr_issue(1'h1, 8'h01, 8'h33);
      @(negedge sys_clk);
      `CHECK("illegal no-wrap", 1'h1, config_illegal_ff)
      $display("Test done: illegal setting");
      finish_test();
   end
endmodule // test_sdram_info_and_burst_order
`default_nettype wire
